// ### hw/tfm_pkg.sv
`default_nettype none
package tfm_pkg;
  localparam int unsigned CLK_PERIOD_NS      = 20;
  localparam int unsigned NUM_DRIVES         = 6;
  localparam int unsigned DRV_IDX_W          = 3;
  localparam int unsigned CHARS_PER_WORD     = 6;
  localparam int unsigned CHAR_BITS          = 6;
  // Bits 31, 32 and 33 sit in lanes 3..5 of their character; a written mark uses lanes 0..2, a read mark is detected in lanes 3..5.
  localparam logic [5:0]  FILE_MARK_CHAR     = 6'h07;
  localparam int unsigned FILE_MARK_OS_NS    = 15000;
  localparam int unsigned FILE_MARK_OS_CYC   = (FILE_MARK_OS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned REWIND_OS_MS       = 40;
  localparam int unsigned REWIND_OS_CYC      = REWIND_OS_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned OSC_GATE_DLY_CYC   = 16;
  localparam int unsigned EOR_DISC_DLY_CYC   = 16;
  localparam int unsigned MPD_TIMEOUT_CYC    = 64;
  localparam int unsigned CNT_W              = 24;
  localparam logic [2:0]  RING_POS_1         = 3'h1;
  localparam logic [2:0]  RING_POS_5         = 3'h5;
  localparam logic [2:0]  RING_POS_6         = 3'h6;

  typedef enum logic [1:0] {TFM_CMD_NONE, TFM_CMD_WRITE_MARK, TFM_CMD_REWIND} tfm_cmd_t;

  typedef struct packed {
    logic                 valid;
    tfm_cmd_t             cmd;
    logic [DRV_IDX_W-1:0] drive;
  } tfm_req_t;

  typedef struct packed {
    logic at_load_point;
    logic out_of_file_area;
    logic rewinding;
    logic ready;
  } tfm_drv_stat_t;
endpackage : tfm_pkg
`default_nettype wire

// ### hw/tfm_one_shot.sv
`default_nettype none
module tfm_one_shot #(
  parameter int unsigned CYCLES = 4,
  parameter int unsigned CNT_W  = 24
) (
  input  wire logic i_sys_clk,  // System clock.
  input  wire logic i_sys_rst,  // Synchronous reset.
  input  wire logic i_fire,     // Trigger pulse.
  output logic      o_active,   // Output level while timing.
  output logic      o_fall      // One-cycle pulse at the end.
);
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             fall;
  } tfm_os_state_t;

  tfm_os_state_t st_q;
  tfm_os_state_t st_d;

  always_comb begin
    st_d      = st_q;
    st_d.fall = 1'b0;
    if (i_fire) begin
      st_d.cnt = CNT_W'(CYCLES);
    end else if (st_q.cnt != '0) begin
      st_d.cnt = st_q.cnt - CNT_W'(1);
      st_d.fall = (st_q.cnt == CNT_W'(1));
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_active = (st_q.cnt != '0);
  assign o_fall   = st_q.fall;
endmodule : tfm_one_shot
`default_nettype wire

// ### hw/tfm_sync2.sv
`default_nettype none
module tfm_sync2 #(
  parameter int unsigned W = 1
) (
  input  wire logic         i_sys_clk,  // System clock.
  input  wire logic         i_sys_rst,  // Synchronous reset.
  input  wire logic [W-1:0] i_async,    // Pin level.
  output logic      [W-1:0] o_sync      // Synchronised level.
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } tfm_sy_state_t;

  tfm_sy_state_t st_q;
  tfm_sy_state_t st_d;

  always_comb begin
    st_d.s1 = i_async;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_sync = st_q.s2;
endmodule : tfm_sync2
`default_nettype wire

// ### hw/tfm_tape_ctrl.sv
// The address-and-strobe port and the register offsets were left to the implementer.
`default_nettype none
module tfm_tape_ctrl #(
  parameter int unsigned REWIND_CYC  = tfm_pkg::REWIND_OS_CYC,
  parameter int unsigned MARK_OS_CYC = tfm_pkg::FILE_MARK_OS_CYC,
  parameter int unsigned OSC_DLY_CYC = tfm_pkg::OSC_GATE_DLY_CYC,
  parameter int unsigned EOR_DLY_CYC = tfm_pkg::EOR_DISC_DLY_CYC,
  parameter int unsigned MPD_CYC     = tfm_pkg::MPD_TIMEOUT_CYC
) (
  input  wire logic                     i_sys_clk,          // System clock, 50 MHz.
  input  wire logic                     i_sys_rst,          // Synchronous reset.
  input  wire logic                     i_select_pulse,     // Drive selection instruction.
  input  wire logic [2:0]               i_select_drive,     // Drive index 0..5.
  input  wire tfm_pkg::tfm_req_t        i_op_timing_pulse,  // Command at timing pulse 9.
  input  wire logic                     i_read_start,       // Read selected drive.
  input  wire logic                     i_not_backward,     // Tape not moving backward.
  input  wire logic                     i_char_clk,         // Character clock tick.
  input  wire logic                     i_echo_sync,        // Echo or read sync pin.
  input  wire logic [5:0]               i_read_char,        // Read character pin bits.
  input  wire tfm_pkg::tfm_drv_stat_t   i_drv_stat,         // Selected drive status pins.
  output logic [5:0]                    o_drive_select,     // One-hot drive select.
  output logic                          o_write_status,     // Read/write status, 1 write.
  output logic                          o_motion,           // Motion flag to drive.
  output logic                          o_osc_gate,         // Character clock enabled.
  output logic [5:0]                    o_write_bus,        // Write character lanes.
  output logic                          o_write_strobe,     // Write pulse.
  output logic                          o_data_request,     // Request for data transfer.
  output logic                          o_set_out_of_file,  // Set drive latch pulse level.
  output logic                          o_start_rewind,     // Start-rewind pulse level.
  output logic                          o_io_interlock,     // I/O interlock.
  output logic                          o_prepared,         // Drive prepared.
  output logic                          o_ready,            // Drive ready.
  output logic                          o_file_mark_flag,   // File-mark flag.
  output logic                          o_disconnect        // Ends the instruction.
);
  typedef enum {ST_IDLE, ST_W_DELAY, ST_W_RUN, ST_W_MPD, ST_R_RUN, ST_R_MPD,
                ST_EOR_DLY} tfm_ctl_state_t;

  typedef struct packed {
    tfm_ctl_state_t   state;
    logic [5:0]       sel;
    logic             write_status;
    logic             motion;
    logic             osc_gate;
    logic             mark;
    logic             wcz;
    logic             wcz2;
    logic [2:0]       ring;
    logic [5:0]       wbus;
    logic             wstrobe;
    logic             dreq;
    logic             interlock;
    logic             disc;
    logic [23:0]      cnt;
    logic [23:0]      missing_pulse_detector;
    logic             clk_run;
  } tfm_ctl_st_t;

  tfm_ctl_st_t st_q;
  tfm_ctl_st_t st_d;

  logic [5:0]              rd_char_s;
  logic [2:0]              misc_s;
  tfm_pkg::tfm_drv_stat_t  stat_s;
  logic                    mark_fire;
  logic                    mark_os_active;
  logic                    rew_fire;
  logic                    rew_os_active;
  logic                    rew_os_fall;
  logic                    sync_s;
  logic                    char_s;
  logic                    notbk_s;

  function automatic logic [5:0] tfm_onehot(input logic [2:0] idx);
    logic [5:0] v;
    v = '0;
    if (idx < 3'(tfm_pkg::NUM_DRIVES)) begin
      v[idx] = 1'b1;
    end
    return v;
  endfunction : tfm_onehot

  function automatic logic [2:0] tfm_ring_next(input logic [2:0] r);
    return (r == tfm_pkg::RING_POS_6) ? tfm_pkg::RING_POS_1 : r + 3'h1;
  endfunction : tfm_ring_next

  tfm_sync2 #(.W(6)) u_sync_char (
    .i_sys_clk (i_sys_clk),
    .i_sys_rst (i_sys_rst),
    .i_async   (i_read_char),
    .o_sync    (rd_char_s)
  );

  tfm_sync2 #(.W(7)) u_sync_misc (
    .i_sys_clk (i_sys_clk),
    .i_sys_rst (i_sys_rst),
    .i_async   ({i_echo_sync, i_char_clk, i_not_backward, i_drv_stat}),
    .o_sync    ({misc_s, stat_s})
  );

  assign sync_s  = misc_s[2];
  assign char_s  = misc_s[1];
  assign notbk_s = misc_s[0];

  tfm_one_shot #(.CYCLES(MARK_OS_CYC), .CNT_W(tfm_pkg::CNT_W)) u_mark_os (
    .i_sys_clk (i_sys_clk),
    .i_sys_rst (i_sys_rst),
    .i_fire    (mark_fire),
    .o_active  (mark_os_active),
    .o_fall    ()
  );

  tfm_one_shot #(.CYCLES(REWIND_CYC), .CNT_W(tfm_pkg::CNT_W)) u_rewind_os (
    .i_sys_clk (i_sys_clk),
    .i_sys_rst (i_sys_rst),
    .i_fire    (rew_fire),
    .o_active  (rew_os_active),
    .o_fall    (rew_os_fall)
  );

  always_comb begin
    st_d         = st_q;
    st_d.wstrobe = 1'b0;
    st_d.dreq    = 1'b0;
    st_d.disc    = 1'b0;
    mark_fire    = 1'b0;
    rew_fire     = 1'b0;

    if (i_select_pulse) begin
      st_d.sel = tfm_onehot(i_select_drive);
    end

    // Rewind is taken in any interlock or prepared state.
    if (i_op_timing_pulse.valid && i_op_timing_pulse.cmd == tfm_pkg::TFM_CMD_REWIND) begin
      if (stat_s.at_load_point) begin
        st_d.disc = 1'b1;
      end else begin
        rew_fire       = 1'b1;
        st_d.interlock = 1'b1;
      end
    end
    if (rew_os_fall) begin
      // A mark write still in progress keeps its own interlock.
      st_d.interlock = (st_q.state != ST_IDLE);
      st_d.disc      = 1'b1;
    end

    // The echo sync is the only sign of tape life; the counter stands in for the detector.
    if (sync_s) begin
      st_d.missing_pulse_detector = 24'(MPD_CYC);
    end else if (st_q.missing_pulse_detector != '0) begin
      st_d.missing_pulse_detector = st_q.missing_pulse_detector - 24'h1;
    end

    unique case (st_q.state)
      ST_IDLE: begin
        if (i_op_timing_pulse.valid &&
            i_op_timing_pulse.cmd == tfm_pkg::TFM_CMD_WRITE_MARK) begin
          st_d.mark         = 1'b1;
          st_d.wcz          = 1'b1;
          st_d.wcz2         = 1'b0;
          st_d.write_status = 1'b1;
          st_d.motion       = 1'b1;
          st_d.interlock    = 1'b1;
          st_d.ring         = tfm_pkg::RING_POS_1;
          st_d.cnt          = 24'(OSC_DLY_CYC);
          st_d.state        = ST_W_DELAY;
        end else if (i_read_start) begin
          st_d.mark         = 1'b0;
          st_d.write_status = 1'b0;
          st_d.motion       = 1'b1;
          st_d.ring         = tfm_pkg::RING_POS_1;
          st_d.missing_pulse_detector          = 24'(MPD_CYC);
          st_d.state        = ST_R_RUN;
        end
      end
      ST_W_DELAY: begin
        if (st_q.cnt == 24'h1) begin
          st_d.osc_gate = 1'b1;
          st_d.clk_run  = 1'b1;
          st_d.state    = ST_W_RUN;
        end
        st_d.cnt = st_q.cnt - 24'h1;
      end
      ST_W_RUN: begin
        if (char_s && st_q.clk_run) begin
          st_d.wstrobe = 1'b1;
          // Word register is clear, so only the mark lanes ever carry ones.
          st_d.wbus = (st_q.mark && st_q.ring == tfm_pkg::RING_POS_1)
                      ? tfm_pkg::FILE_MARK_CHAR : 6'h00;
          st_d.dreq = !st_q.mark;
          if (st_q.ring == tfm_pkg::RING_POS_1 && st_q.mark) begin
            mark_fire = 1'b1;
          end
          if (st_q.ring == tfm_pkg::RING_POS_5 && st_q.wcz) begin
            st_d.wcz2 = 1'b1;
          end
          if (st_q.ring == tfm_pkg::RING_POS_6 && st_q.wcz2) begin
            st_d.osc_gate = 1'b0;
            st_d.clk_run  = 1'b0;
            st_d.state    = ST_W_MPD;
          end
          st_d.ring = tfm_ring_next(st_q.ring);
        end
      end
      ST_W_MPD, ST_R_MPD: begin
        if (st_q.missing_pulse_detector == '0) begin
          st_d.motion = 1'b0;
          st_d.cnt    = 24'(EOR_DLY_CYC);
          st_d.state  = ST_EOR_DLY;
        end
      end
      ST_R_RUN: begin
        if (char_s) begin
          if (st_q.ring == tfm_pkg::RING_POS_1 && rd_char_s[5:3] == 3'h7 &&
              sync_s && notbk_s) begin
            mark_fire = 1'b1;
            st_d.mark = 1'b1;
          end
          st_d.dreq = !st_q.mark && !(st_q.ring == tfm_pkg::RING_POS_1 &&
                      rd_char_s[5:3] == 3'h7 && sync_s && notbk_s);
          st_d.ring = tfm_ring_next(st_q.ring);
        end
        if (st_q.missing_pulse_detector == '0) begin
          st_d.state = ST_R_MPD;
        end
      end
      ST_EOR_DLY: begin
        st_d.cnt = st_q.cnt - 24'h1;
        if (st_q.cnt == 24'h1) begin
          st_d.disc         = 1'b1;
          st_d.interlock    = rew_os_active || rew_fire;
          st_d.write_status = 1'b0;
          st_d.wbus         = 6'h00;
          st_d.state        = ST_IDLE;
        end
      end
      default: begin
        st_d.state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      st_q       <= '0;
      st_q.state <= ST_IDLE;
      st_q.ring  <= tfm_pkg::RING_POS_1;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_drive_select    = st_q.sel;
  assign o_write_status    = st_q.write_status;
  assign o_motion          = st_q.motion;
  assign o_osc_gate        = st_q.osc_gate;
  assign o_write_bus       = st_q.wbus;
  assign o_write_strobe    = st_q.wstrobe;
  assign o_data_request    = st_q.dreq;
  assign o_set_out_of_file = mark_os_active;
  assign o_start_rewind    = rew_os_active;
  assign o_io_interlock    = st_q.interlock;
  // Drive rewind status covers the whole rewind, not only the 40 ms pulse.
  assign o_prepared = !stat_s.out_of_file_area && !stat_s.rewinding &&
                      !rew_os_active;
  assign o_ready          = stat_s.ready;
  assign o_file_mark_flag = st_q.mark;
  assign o_disconnect     = st_q.disc;
endmodule : tfm_tape_ctrl
`default_nettype wire

// ### tb/tfm_chk_sva.sv
`default_nettype none
module tfm_chk #(
  parameter int unsigned REWIND_CYC  = 50,
  parameter int unsigned MARK_OS_CYC = 750,
  parameter int unsigned OSC_DLY_CYC = 16
) (
  input wire logic                   i_sys_clk,         // Clock.
  input wire logic                   i_sys_rst,         // Reset.
  input wire logic                   i_select_pulse,    // Select.
  input wire logic [2:0]             i_select_drive,    // Index.
  input wire tfm_pkg::tfm_req_t      i_op_timing_pulse, // Command.
  input wire tfm_pkg::tfm_drv_stat_t i_drv_stat,        // Pins.
  input wire logic [5:0]             o_drive_select,    // One-hot.
  input wire logic                   o_write_status,    // Write.
  input wire logic                   o_motion,          // Motion.
  input wire logic                   o_osc_gate,        // Gate.
  input wire logic                   o_data_request,    // Request.
  input wire logic                   o_set_out_of_file, // Latch set.
  input wire logic                   o_start_rewind,    // Rewind.
  input wire logic                   o_io_interlock,    // Interlock.
  input wire logic                   o_file_mark_flag,  // Mark.
  input wire logic                   o_disconnect       // End.
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int OSC_HI = OSC_DLY_CYC + 2;
  int oof_n_q;
  int rew_n_q;
  int live_q;
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_sys_rst);
  // The synchronisers restart at zero, so pin history is trusted only a while after reset.
  always_ff @(posedge i_sys_clk) begin
    oof_n_q <= (i_sys_rst || !o_set_out_of_file) ? 0 : oof_n_q + 1;
    rew_n_q <= (i_sys_rst || !o_start_rewind) ? 0 : rew_n_q + 1;
    live_q  <= i_sys_rst ? 0 : (live_q < 8 ? live_q + 1 : live_q);
  end
  AST_SELECT:
  assert property (i_select_pulse |=> o_drive_select == ($past(i_select_drive) < 3'h6 ?
    6'h01 << $past(i_select_drive) : 6'h00)) else $error("wrong drive selected");
  AST_WM_START:
  assert property (i_op_timing_pulse.valid && i_op_timing_pulse.cmd == tfm_pkg::TFM_CMD_WRITE_MARK
    && !o_io_interlock && !o_motion && !o_start_rewind |=> o_io_interlock && o_write_status
    && o_motion && o_file_mark_flag) else $error("mark write did not start");
  AST_OSC_DLY:
  assert property ($rose(o_motion) && o_write_status |-> !o_osc_gate ##[1:OSC_HI] o_osc_gate)
    else $error("oscillator gate late");
  AST_NO_DREQ:
  assert property (o_file_mark_flag |-> !o_data_request) else $error("request with mark flag");
  AST_OOF_LEN:
  assert property ($fell(o_set_out_of_file) |-> oof_n_q == MARK_OS_CYC)
    else $error("latch pulse length wrong");
  AST_RW_LEN:
  assert property ($fell(o_start_rewind) |-> rew_n_q == REWIND_CYC)
    else $error("rewind pulse length wrong");
  AST_RW_DISC:
  assert property ($fell(o_start_rewind) |-> ##[0:1] o_disconnect)
    else $error("no disconnect after rewind pulse");
  AST_RW_LOCK:
  assert property (o_start_rewind |-> o_io_interlock) else $error("interlock low in rewind");
  AST_LP_SKIP:
  assert property (live_q > 4 && i_op_timing_pulse.valid && i_drv_stat.at_load_point
    && i_op_timing_pulse.cmd == tfm_pkg::TFM_CMD_REWIND && $past(i_drv_stat.at_load_point, 3)
    |=> o_disconnect && !o_start_rewind) else $error("load point rewind not skipped");
  cover property (o_disconnect && o_file_mark_flag);
  cover property ($fell(o_start_rewind));
  cover property ($rose(o_set_out_of_file));
endmodule : tfm_chk
bind tfm_tape_ctrl tfm_chk #(.REWIND_CYC(REWIND_CYC), .MARK_OS_CYC(MARK_OS_CYC),
  .OSC_DLY_CYC(OSC_DLY_CYC)) i_tfm_chk (.i_sys_clk, .i_sys_rst, .i_select_pulse,
  .i_select_drive, .i_op_timing_pulse, .i_drv_stat, .o_drive_select, .o_write_status,
  .o_motion, .o_osc_gate, .o_data_request, .o_set_out_of_file, .o_start_rewind,
  .o_io_interlock, .o_file_mark_flag, .o_disconnect);
`default_nettype wire

// ### tb/tfm_drive_model.sv
`default_nettype none
module tfm_drive_model (
  input  wire logic              i_sys_clk,  // Clock.
  input  wire logic              i_sys_rst,  // Reset.
  input  wire logic              i_play,     // Tape holds a mark record.
  input  wire logic              i_load_pt,  // Tape at load point.
  input  wire logic              i_motion,   // Motion.
  input  wire logic              i_wr,       // Write status.
  input  wire logic              i_osc_gate, // Clock gate.
  input  wire logic              i_set_oof,  // Latch set.
  input  wire logic              i_rewind,   // Start-rewind.
  output logic                   o_char_clk, // Character tick.
  output logic                   o_sync,     // Echo or read sync.
  output logic [5:0]             o_char,     // Read lanes.
  output tfm_pkg::tfm_drv_stat_t o_stat      // Status pins.
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] div_q;
  logic [2:0] nch_q;
  logic [4:0] rew_q;
  logic       oof_q;
  logic       rd;
  assign rd = i_play && i_motion && !i_wr && nch_q != 3'h6;
  // Rewind runs on past the start pulse, so disconnect arrives before completion.
  assign o_stat = '{at_load_point: i_load_pt, out_of_file_area: oof_q,
                    rewinding: i_rewind || rew_q != 5'h00, ready: 1'b1};
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      div_q <= 3'h0;
      nch_q <= 3'h0;
      rew_q <= 5'h00;
      oof_q <= 1'b0;
      o_char_clk <= 1'b0;
      o_sync <= 1'b0;
      o_char <= 6'h00;
    end else begin
      div_q <= div_q + 3'h1;
      o_sync <= i_osc_gate || rd;
      o_char_clk <= (i_osc_gate || rd) && div_q == 3'h7;
      if (rd && div_q == 3'h7) begin
        nch_q <= nch_q + 3'h1;
        o_char <= (nch_q == 3'h0) ? 6'h38 : 6'h00;
      end else if (!rd) begin
        o_char <= ~o_char;
      end
      if (i_set_oof) begin
        oof_q <= 1'b1;
      end
      rew_q <= i_rewind ? 5'h14 : (rew_q != 5'h00 ? rew_q - 5'h01 : rew_q);
    end
  end
endmodule : tfm_drive_model
`default_nettype wire

// ### tb/tape_file_mark_and_rewind_control_tb_top.sv
`default_nettype none
module tape_file_mark_and_rewind_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int REW = 50;
  logic i_sys_clk, i_sys_rst, i_select_pulse, i_read_start, i_not_backward, play, load_pt;
  logic [2:0] i_select_drive;
  tfm_pkg::tfm_req_t i_op_timing_pulse;
  tfm_pkg::tfm_drv_stat_t i_drv_stat;
  logic i_char_clk, i_echo_sync, o_write_status, o_motion, o_osc_gate, o_write_strobe;
  logic o_data_request, o_set_out_of_file, o_start_rewind, o_io_interlock, o_prepared;
  logic o_ready, o_file_mark_flag, o_disconnect, seen_oof, seen_mark;
  logic [5:0] i_read_char, o_drive_select, o_write_bus;
  logic [5:0] wb [8];
  logic [7:0] n_strb, n_dreq, n_tick, n_rew;
  int mismatches = 0;
  int n_checks = 0;
  int cyc = 0;
  tfm_tape_ctrl #(.REWIND_CYC(REW), .MARK_OS_CYC(40)) i_tfm_tape_ctrl (.i_sys_clk,
    .i_sys_rst, .i_select_pulse, .i_select_drive, .i_op_timing_pulse, .i_read_start,
    .i_not_backward, .i_char_clk, .i_echo_sync, .i_read_char, .i_drv_stat, .o_drive_select,
    .o_write_status, .o_motion, .o_osc_gate, .o_write_bus, .o_write_strobe, .o_data_request,
    .o_set_out_of_file, .o_start_rewind, .o_io_interlock, .o_prepared, .o_ready,
    .o_file_mark_flag, .o_disconnect);
  tfm_drive_model i_tfm_drive_model (.i_sys_clk, .i_sys_rst, .i_play(play),
    .i_load_pt(load_pt), .i_motion(o_motion), .i_wr(o_write_status), .i_osc_gate(o_osc_gate),
    .i_set_oof(o_set_out_of_file), .i_rewind(o_start_rewind), .o_char_clk(i_char_clk),
    .o_sync(i_echo_sync), .o_char(i_read_char), .o_stat(i_drv_stat));
  initial begin
    i_sys_clk = 1'b0;
    forever #10 i_sys_clk = ~i_sys_clk;
  end
  always @(posedge i_sys_clk) begin
    cyc <= cyc + 1;
    if (o_write_strobe) begin
      wb[n_strb[2:0]] <= o_write_bus;
      n_strb <= n_strb + 8'h01;
    end
    n_dreq <= n_dreq + 8'(o_data_request);
    n_tick <= n_tick + 8'(i_char_clk);
    n_rew <= n_rew + 8'(o_start_rewind);
    seen_oof <= seen_oof | o_set_out_of_file;
    seen_mark <= seen_mark | o_file_mark_flag;
    if (cyc == 20000) begin
      mismatches++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk
  // Counters are cleared off the clock edge so the monitor never races the clear.
  task automatic clr();
    @(negedge i_sys_clk);
    {n_strb, n_dreq, n_tick, n_rew, seen_oof, seen_mark} = '0;
  endtask : clr
  task automatic do_reset();
    @(posedge i_sys_clk);
    i_sys_rst <= 1'b1;
    repeat (3) @(posedge i_sys_clk);
    i_sys_rst <= 1'b0;
  endtask : do_reset
  task automatic sel(input logic [2:0] d);
    @(posedge i_sys_clk);
    i_select_pulse <= 1'b1;
    i_select_drive <= d;
    @(posedge i_sys_clk);
    i_select_pulse <= 1'b0;
    repeat (3) @(posedge i_sys_clk);
  endtask : sel
  task automatic issue(input tfm_pkg::tfm_cmd_t c);
    @(posedge i_sys_clk);
    i_op_timing_pulse <= '{valid: 1'b1, cmd: c, drive: 3'h2};
    @(posedge i_sys_clk);
    i_op_timing_pulse.valid <= 1'b0;
  endtask : issue
  task automatic wait_disc(input int lim, output int n);
    n = 0;
    do begin
      @(negedge i_sys_clk);
      n++;
    end while (o_disconnect !== 1'b1 && n < lim);
    chk("disconnect seen", 8'(n < lim), 8'h01);
  endtask : wait_disc
  task automatic t_select();
    for (int d = 0; d < 8; d++) begin
      sel(3'(d));
      chk("drive select", o_drive_select, d < 6 ? 8'h01 << d : 8'h00);
    end
    sel(3'h2);
  endtask : t_select
  task automatic t_write();
    int n;
    clr();
    chk("prepared", o_prepared, 8'h01);
    chk("ready", o_ready, 8'h01);
    issue(tfm_pkg::TFM_CMD_WRITE_MARK);
    @(negedge i_sys_clk);
    chk("interlock", o_io_interlock, 8'h01);
    chk("write status", {o_write_status, o_motion}, 8'h03);
    chk("mark flag", o_file_mark_flag, 8'h01);
    wait_disc(1500, n);
    chk("strobes", n_strb, 8'h06);
    chk("mark char", wb[0], 8'h07);
    chk("later char", wb[5], 8'h00);
    chk("requests", n_dreq, 8'h00);
    chk("latch pulse", seen_oof, 8'h01);
    repeat (2) @(negedge i_sys_clk);
    chk("interlock", o_io_interlock, 8'h00);
    chk("prepared", o_prepared, 8'h00);
  endtask : t_write
  task automatic t_read(input logic nb);
    int n;
    clr();
    @(posedge i_sys_clk);
    i_not_backward <= nb;
    play <= 1'b1;
    i_read_start <= 1'b1;
    @(posedge i_sys_clk);
    i_read_start <= 1'b0;
    wait_disc(2000, n);
    chk("mark flag", seen_mark, 8'(nb));
    chk("requests", n_dreq, nb ? 8'h00 : 8'h06);
    chk("latch pulse", seen_oof, 8'(nb));
    chk("ticks", n_tick, 8'h06);
    repeat (4) @(negedge i_sys_clk);
    chk("prepared", o_prepared, 8'(!nb));
  endtask : t_read
  task automatic t_rewind(input logic lp, input logic prep);
    int n;
    @(posedge i_sys_clk);
    load_pt <= lp;
    repeat (5) @(posedge i_sys_clk);
    clr();
    chk("prepared before", o_prepared, 8'(prep));
    issue(tfm_pkg::TFM_CMD_REWIND);
    wait_disc(REW + 8, n);
    if (lp) begin
      chk("skip delay", 8'(n), 8'h01);
      chk("rewind pulse", n_rew, 8'h00);
    end else begin
      chk("rewind pulse", n_rew, 8'(REW));
      chk("prepared at end", o_prepared, 8'h00);
    end
    repeat (30) @(negedge i_sys_clk);
    chk("prepared after", o_prepared, 8'(prep));
  endtask : t_rewind
  initial begin
    {i_select_pulse, i_read_start, play, load_pt} = '0;
    i_sys_rst = 1'b1;
    i_not_backward = 1'b1;
    i_select_drive = 3'h0;
    i_op_timing_pulse = '0;
    repeat (3) @(posedge i_sys_clk);
    i_sys_rst <= 1'b0;
    t_select();
    t_write();
    t_rewind(1'b0, 1'b0);
    do_reset();
    sel(3'h2);
    t_read(1'b0);
    do_reset();
    sel(3'h2);
    t_read(1'b1);
    do_reset();
    sel(3'h2);
    t_rewind(1'b0, 1'b1);
    t_rewind(1'b1, 1'b1);
    print_verdict();
  end
endmodule : tape_file_mark_and_rewind_control_tb_top
`default_nettype wire
